// ==== rtl/blc_core.sv ====
// burst column ordering and latency configuration core of the memory device

// ---------------------------------------------
// rule summary
// ---------------------------------------------
module blc_core (
	// system clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// command link from the memory controller
	input wire logic link_clk,
	input wire logic cmd_valid,
	input wire blc_pkg::blc_cmd_t cmd,
	output logic link_busy_q,
	// selects held in other mode registers
	input wire logic setpoint_write_select,
	input wire logic setpoint_operate_select,
	input wire logic data_inversion_rd_en,
	// beat stream and read answer
	output blc_pkg::blc_beat_t beat_q,
	output logic strobe_q,
	output logic [7:0] mrr_data_q,
	// decoded operating values
	output blc_pkg::blc_lat_t lat_q,
	output logic write_leveling_q
);

	// ---------------------------------------------
	// link domain: command capture
	// ---------------------------------------------
	blc_pkg::blc_cmd_t link_cmd_q;
	logic link_req_q;
	logic ack_m_q;
	logic ack_s_q;
	logic ack_q;
	logic accept;

	// a command is taken only while the previous one is not in flight
	assign accept = cmd_valid && !link_busy_q && (cmd.kind != blc_pkg::CMD_NOP);

	// hold the command word and flip the request toggle
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_cmd_q <= '0;
			link_req_q <= 1'b0;
		end else if (accept) begin
			link_cmd_q <= cmd;
			link_req_q <= ~link_req_q;
		end
	end

	// bring the acknowledge toggle back onto the link clock
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_m_q <= 1'b0;
			ack_s_q <= 1'b0;
		end else begin
			ack_m_q <= ack_q;
			ack_s_q <= ack_m_q;
		end
	end

	// busy from the take until the core has acknowledged it
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_busy_q <= 1'b0;
		end else begin
			link_busy_q <= accept || (link_req_q != ack_s_q);
		end
	end

	// ---------------------------------------------
	// core domain: crossings
	// ---------------------------------------------
	logic req_m_q;
	logic req_s_q;
	logic [2:0] sel_m_q;
	logic [2:0] sel_s_q;
	logic evt;

	// request toggle through two flops, ack follows the synced copy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_m_q <= 1'b0;
			req_s_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			req_m_q <= link_req_q;
			req_s_q <= req_m_q;
			ack_q <= req_s_q;
		end
	end

	// selects from other registers arrive asynchronously
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_m_q <= 3'h0;
			sel_s_q <= 3'h0;
		end else begin
			sel_m_q <= {data_inversion_rd_en, setpoint_operate_select, setpoint_write_select};
			sel_s_q <= sel_m_q;
		end
	end

	// one-cycle pulse per command; the word is stable while it is unacknowledged
	assign evt = req_s_q ^ ack_q;

	// ---------------------------------------------
	// command decode
	// ---------------------------------------------
	blc_pkg::blc_state_t st_q;
	logic lat_wr;
	logic go_rw;
	logic go_mrr;
	logic is_write;
	logic [7:0] cfg;

	assign is_write = link_cmd_q.kind == blc_pkg::CMD_WRITE;

	// only address 02H updates the latency copies
	assign lat_wr = evt && (link_cmd_q.kind == blc_pkg::CMD_REG_WRITE) &&
		(link_cmd_q.ma == blc_pkg::MA_LATENCY);

	// leveling lets nothing but mode writes through
	assign go_rw = evt && !write_leveling_q && (st_q == blc_pkg::ST_IDLE) &&
		(is_write || (link_cmd_q.kind == blc_pkg::CMD_READ));
	assign go_mrr = evt && !write_leveling_q && (st_q == blc_pkg::ST_IDLE) &&
		(link_cmd_q.kind == blc_pkg::CMD_MRR);

	// ---------------------------------------------
	// set point copies of the latency register
	// ---------------------------------------------
	blc_setpoint_store #(
		.WIDTH(8),
		.ENTRIES(2)
	) u_store (
		.clk(clk),
		.rst_n(rst_n),
		.wr_en(lat_wr),
		.wr_sel(sel_s_q[0]),
		.wr_data(link_cmd_q.op),
		.rd_sel(sel_s_q[1]),
		.rd_data_q(cfg)
	);

	// ---------------------------------------------
	// latency decode from the active copy
	// ---------------------------------------------
	logic [2:0] rd_code;
	logic [2:0] wr_code;

	assign rd_code = cfg[blc_pkg::RD_LAT_LSB +: 3];
	assign wr_code = cfg[blc_pkg::WR_LAT_LSB +: 3];

	// read latency follows the inversion enable, write latency the set bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lat_q.read_latency <= blc_pkg::RD_LAT_PLAIN[0];
			lat_q.read_to_precharge_cycles <= blc_pkg::RTP[0];
			lat_q.write_latency <= blc_pkg::WR_LAT_SET_A[0];
		end else begin
			if (sel_s_q[2]) begin
				lat_q.read_latency <= blc_pkg::RD_LAT_INV[rd_code];
			end else begin
				lat_q.read_latency <= blc_pkg::RD_LAT_PLAIN[rd_code];
			end
			lat_q.read_to_precharge_cycles <= blc_pkg::RTP[rd_code];
			if (cfg[blc_pkg::WR_SET_BIT]) begin
				lat_q.write_latency <= blc_pkg::WR_LAT_SET_B[wr_code];
			end else begin
				lat_q.write_latency <= blc_pkg::WR_LAT_SET_A[wr_code];
			end
		end
	end

	// leveling stays set until a write clears the bit in the active copy or the operate select picks a copy without it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_leveling_q <= 1'b0;
		end else begin
			write_leveling_q <= cfg[blc_pkg::WRLVL_BIT];
		end
	end

	// ---------------------------------------------
	// burst engine
	// ---------------------------------------------
	logic [4:0] idx_q;
	logic [3:0] base_q;
	logic long_q;
	logic wr_q;
	logic half_q;
	logic [4:0] last_idx;

	assign last_idx = long_q ? blc_pkg::LAST_LONG : blc_pkg::LAST_SHORT;

	// idle, data burst or register read answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= blc_pkg::ST_IDLE;
		end else begin
			case (st_q)
				blc_pkg::ST_IDLE: begin
					if (go_rw) begin
						st_q <= blc_pkg::ST_BURST;
					end else if (go_mrr) begin
						st_q <= blc_pkg::ST_MRR;
					end
				end
				blc_pkg::ST_BURST, blc_pkg::ST_MRR: begin
					if (idx_q == last_idx) begin
						st_q <= blc_pkg::ST_IDLE;
					end
				end
				default: begin
					st_q <= blc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// burst parameters taken with the command
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			base_q <= 4'h0;
			long_q <= 1'b0;
			wr_q <= 1'b0;
			half_q <= 1'b0;
		end else if (go_rw) begin
			// writes always start on a 16-word boundary
			base_q <= is_write ? 4'h0 : {link_cmd_q.col[3:2], 2'b00};
			long_q <= link_cmd_q.long_burst;
			wr_q <= is_write;
			half_q <= link_cmd_q.col[4];
		end else if (go_mrr) begin
			long_q <= 1'b0;
			wr_q <= 1'b0;
		end
	end

	// beat counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_q <= 5'h00;
		end else if (st_q == blc_pkg::ST_IDLE) begin
			idx_q <= 5'h00;
		end else begin
			idx_q <= idx_q + 5'h01;
		end
	end

	// column per beat: low nibble wraps in 16, bit 4 flips for the second half
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			beat_q <= '0;
		end else begin
			beat_q.valid <= st_q == blc_pkg::ST_BURST;
			beat_q.write <= wr_q;
			beat_q.last <= (st_q == blc_pkg::ST_BURST) && (idx_q == last_idx);
			beat_q.col <= {half_q ^ idx_q[4], 4'(base_q + idx_q[3:0])};
		end
	end

	// strobe toggles on read beats and on register read answers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_q <= 1'b0;
		end else if ((st_q == blc_pkg::ST_MRR) || ((st_q == blc_pkg::ST_BURST) && !wr_q)) begin
			strobe_q <= ~strobe_q;
		end else begin
			strobe_q <= 1'b0;
		end
	end

	// write-only register reads return filler
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mrr_data_q <= 8'h00;
		end else begin
			mrr_data_q <= (st_q == blc_pkg::ST_MRR) ? blc_pkg::MRR_FILL : 8'h00;
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_read_wrap: assert property (
		beat_q.valid && !beat_q.write && !beat_q.last |=> beat_q.col[3:0] == 4'($past(beat_q.col[3:0]) + 4'h1))
		else $error("read beat order broken");
	a_half_swap: assert property (
		beat_q.valid && $past(idx_q) == 5'h10 |-> beat_q.col[4] != $past(half_q))
		else $error("second half not swapped");
	a_last_beat: assert property (
		beat_q.last |-> $past(idx_q) == ($past(long_q) ? 5'h1f : 5'h0f))
		else $error("burst length wrong");
	a_write_start: assert property (
		$rose(beat_q.valid) && beat_q.write |-> beat_q.col == {$past(half_q), 4'h0})
		else $error("write burst start column wrong");
	a_level_block: assert property (
		write_leveling_q && evt |=> ##1 !beat_q.valid && st_q == blc_pkg::ST_IDLE)
		else $error("command ran during leveling");
	a_rtp_pair: assert property (
		lat_q.read_latency <= 6'h16 |-> lat_q.read_to_precharge_cycles == 5'h08)
		else $error("precharge value does not match latency");
	a_mrr_strobe: assert property (
		st_q == blc_pkg::ST_MRR |=> strobe_q != $past(strobe_q) && mrr_data_q == blc_pkg::MRR_FILL)
		else $error("register read answer missing");
	a_link_hold: assert property (@(posedge link_clk) disable iff (!rst_n)
		link_busy_q |=> $stable(link_cmd_q))
		else $error("command word changed while in flight");

	c_read32: cover property ($rose(beat_q.valid) && !beat_q.write && long_q);
	c_write_upper: cover property ($rose(beat_q.valid) && beat_q.write && beat_q.col[4]);
	c_leveling: cover property ($rose(write_leveling_q) ##[1:200] $fell(write_leveling_q));
	c_mrr: cover property ($rose(st_q == blc_pkg::ST_MRR));

endmodule : blc_core

// ==== rtl/blc_pkg.sv ====
// shared constants and types for the burst order and latency block
package blc_pkg;

	// ---------------------------------------------
	// latency register addressing and layout
	// ---------------------------------------------
	localparam logic [5:0] MA_LATENCY = 6'h02;
	localparam logic [7:0] LATENCY_RESET = 8'h00;
	localparam int RD_LAT_LSB = 0;
	localparam int WR_LAT_LSB = 3;
	localparam int WR_SET_BIT = 6;
	localparam int WRLVL_BIT = 7;
	// data returned on a read of a write-only register (arbitrary pattern)
	localparam logic [7:0] MRR_FILL = 8'ha5;

	// ---------------------------------------------
	// burst geometry
	// ---------------------------------------------
	localparam logic [4:0] LAST_SHORT = 5'h0f;
	localparam logic [4:0] LAST_LONG = 5'h1f;

	// ---------------------------------------------
	// latency tables, index is the 3-bit code
	// ---------------------------------------------
	localparam logic [5:0] RD_LAT_PLAIN [8] = '{6'h06, 6'h0a, 6'h0e, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h24};
	localparam logic [5:0] RD_LAT_INV [8] = '{6'h06, 6'h0c, 6'h10, 6'h16, 6'h1c, 6'h20, 6'h24, 6'h28};
	localparam logic [4:0] RTP [8] = '{5'h08, 5'h08, 5'h08, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10};
	localparam logic [5:0] WR_LAT_SET_A [8] = '{6'h04, 6'h06, 6'h08, 6'h0a, 6'h0c, 6'h0e, 6'h10, 6'h12};
	localparam logic [5:0] WR_LAT_SET_B [8] = '{6'h04, 6'h08, 6'h0c, 6'h12, 6'h16, 6'h1a, 6'h1e, 6'h22};

	// ---------------------------------------------
	// commands, states and carriers
	// ---------------------------------------------
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_READ = 3'h1,
		CMD_WRITE = 3'h2,
		CMD_REG_WRITE = 3'h3,
		CMD_MRR = 3'h4
	} blc_cmd_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_BURST = 2'h1,
		ST_MRR = 2'h2
	} blc_state_t;

	typedef struct packed {
		blc_cmd_kind_t kind;
		logic long_burst;
		logic [4:0] col;
		logic [5:0] ma;
		logic [7:0] op;
	} blc_cmd_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic last;
		logic [4:0] col;
	} blc_beat_t;

	typedef struct packed {
		logic [5:0] read_latency;
		logic [4:0] read_to_precharge_cycles;
		logic [5:0] write_latency;
	} blc_lat_t;

endpackage : blc_pkg

// ==== rtl/blc_setpoint_store.sv ====
// two set point copies of the latency register with registered read
module blc_setpoint_store #(
	parameter int WIDTH = 8,
	parameter int ENTRIES = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write side
	input wire logic wr_en,
	input wire logic wr_sel,
	input wire logic [WIDTH-1:0] wr_data,
	// read side
	input wire logic rd_sel,
	output logic [WIDTH-1:0] rd_data_q
);

	logic [WIDTH-1:0] mem_q [ENTRIES];

	// refuse shapes the one-bit selects cannot serve
	if (ENTRIES != 2 || WIDTH < 8) begin : g_check
		$error("setpoint store needs two entries of at least eight bits");
	end

	// ---------------------------------------------
	// one copy per set point
	// ---------------------------------------------
	for (genvar i = 0; i < ENTRIES; i++) begin : g_copy
		// only the copy picked by the write select changes
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mem_q[i] <= WIDTH'(blc_pkg::LATENCY_RESET);
			end else if (wr_en && (wr_sel == 1'(i))) begin
				mem_q[i] <= wr_data;
			end
		end
	end

	// active copy only reaches the core
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_q <= WIDTH'(blc_pkg::LATENCY_RESET);
		end else begin
			rd_data_q <= mem_q[rd_sel];
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	a_inactive_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(rd_data_q) |-> ($past(rd_sel) != $past(rd_sel, 2)) ||
			($past(wr_en, 2) && ($past(wr_sel, 2) == $past(rd_sel, 2))))
		else $error("active copy changed without a write to it");
	a_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_en && wr_sel == rd_sel) ##1 (rd_sel == $past(rd_sel) && !wr_en) |=> rd_data_q == $past(wr_data, 2))
		else $error("write to the active copy not seen");

endmodule : blc_setpoint_store

// ==== test/blc_ctrl_model.sv ====
// memory controller model driving the command link
module blc_ctrl_model (
	// link side
	input wire logic link_clk,
	input wire logic link_busy_q,
	output blc_pkg::blc_cmd_t cmd,
	output logic cmd_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end
	// offer one command, hold it until taken, then wait out busy
	task automatic send(input blc_pkg::blc_cmd_t c, output bit ok);
		bit free;
		ok = 1'b0;
		c.col[1:0] = 2'h0;
		if (c.kind == blc_pkg::CMD_WRITE) c.col[3:2] = 2'h0;
		@(posedge link_clk);
		#2;
		cmd_valid = 1'b1;
		cmd = c;
		for (int k = 0; k < 40 && !ok; k++) begin
			@(negedge link_clk);
			free = !link_busy_q;
			@(posedge link_clk);
			ok = free;
		end
		#2;
		cmd_valid = 1'b0;
		// released lines must not keep the last value
		cmd = ~c;
		ok = 1'b0;
		for (int k = 0; k < 40 && !ok; k++) begin
			@(negedge link_clk);
			ok = (k > 0) && !link_busy_q;
		end
	endtask : send
endmodule : blc_ctrl_model

// ==== test/test_burst_order_latency_config.sv ====
// self-checking bench for the burst order and latency core
module test_burst_order_latency_config;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, link_clk, rst_n, wsel, osel, inv, cmd_valid, link_busy_q, strobe_q, write_leveling_q, s;
	blc_pkg::blc_cmd_t cmd;
	blc_pkg::blc_beat_t beat_q;
	blc_pkg::blc_lat_t lat_q;
	logic [7:0] mrr_data_q;
	logic [7:0] exp_q[$];
	logic [2:0] r;
	int seed, err_count, n_checks;
	int rd0[8] = '{6, 10, 14, 20, 24, 28, 32, 36};
	int rd1[8] = '{6, 12, 16, 22, 28, 32, 36, 40};
	int rtp[8] = '{8, 8, 8, 8, 10, 12, 14, 16};
	int wra[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
	int wrb[8] = '{4, 8, 12, 18, 22, 26, 30, 34};

	blc_core blc_core_inst (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd),
		.link_busy_q(link_busy_q), .setpoint_write_select(wsel), .setpoint_operate_select(osel),
		.data_inversion_rd_en(inv), .beat_q(beat_q), .strobe_q(strobe_q), .mrr_data_q(mrr_data_q),
		.lat_q(lat_q), .write_leveling_q(write_leveling_q));
	blc_ctrl_model blc_ctrl_model_inst (.link_clk(link_clk), .link_busy_q(link_busy_q), .cmd(cmd),
		.cmd_valid(cmd_valid));

	// core clock and unrelated link clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end

	// ---------------------------------------------
	// checking and closing
	// ---------------------------------------------
	task automatic check(input logic [16:0] seen, input logic [16:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test
	// every beat is compared with the oldest note
	always @(negedge clk) begin
		if (beat_q.valid === 1'b1) begin
			if (exp_q.size() == 0) check(beat_q, 17'h1ffff, "unexpected beat");
			else check(beat_q, exp_q.pop_front(), "beat order");
		end
	end

	// ---------------------------------------------
	// drivers
	// ---------------------------------------------
	task automatic issue(input blc_pkg::blc_cmd_kind_t kind, input logic b32, input logic [4:0] col,
		input logic [5:0] ma, input logic [7:0] op);
		bit ok;
		blc_ctrl_model_inst.send({kind, b32, col, ma, op}, ok);
		if (!ok) begin
			err_count++;
			finish_test();
		end
	endtask : issue
	task automatic reg_write(input logic [5:0] ma, input logic [7:0] op);
		issue(blc_pkg::CMD_REG_WRITE, 1'b0, 5'h00, ma, op);
		repeat (6) @(posedge clk);
	endtask : reg_write
	task automatic set_sel(input logic w, input logic o, input logic d);
		@(posedge clk);
		#2;
		wsel = w;
		osel = o;
		inv = d;
		repeat (6) @(posedge clk);
	endtask : set_sel
	task automatic lat_chk(input logic [2:0] rcode, input logic [2:0] wcode, input bit wset);
		logic [16:0] e;
		e = {6'(inv ? rd1[rcode] : rd0[rcode]), 5'(rtp[rcode]), 6'(wset ? wrb[wcode] : wra[wcode])};
		check(lat_q, e, "latency");
	endtask : lat_chk
	// note the expected beats, send the command, wait for the stream to drain
	task automatic burst(input bit wr, input bit b32, input logic [4:0] col);
		logic [4:0] e;
		for (int i = 0; i < (b32 ? 32 : 16); i++) begin
			e[4] = col[4] ^ (i >= 16);
			e[3:0] = wr ? i[3:0] : {col[3:2], 2'h0} + i[3:0];
			exp_q.push_back({1'b1, wr, i == (b32 ? 31 : 15), e});
		end
		issue(wr ? blc_pkg::CMD_WRITE : blc_pkg::CMD_READ, b32, col, 6'h00, 8'h00);
		for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(negedge clk);
		if (exp_q.size() > 0) begin
			err_count++;
			finish_test();
		end
		repeat (2) @(posedge clk);
	endtask : burst

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		seed = 64551;
		rst_n = 1'b0;
		wsel = 1'b0;
		osel = 1'b0;
		inv = 1'b0;
		repeat (16) @(posedge clk);
		#2;
		rst_n = 1'b1;
		repeat (4) @(posedge clk);
		lat_chk(3'h0, 3'h0, 1'b0);
		check(write_leveling_q, 17'h0, "leveling reset");
		$display("test reset done");
		r = 3'($random(seed));
		for (int i = 0; i < 16; i++) begin
			set_sel(1'b0, 1'b0, i[3]);
			reg_write(6'h02, {1'b0, i[3], i[2:0] + r, i[2:0]});
			lat_chk(i[2:0], i[2:0] + r, i[3]);
			set_sel(1'b0, 1'b0, ~i[3]);
			lat_chk(i[2:0], i[2:0] + r, i[3]);
		end
		$display("test latency codes done");
		set_sel(1'b0, 1'b0, 1'b0);
		reg_write(6'h02, 8'h00);
		set_sel(1'b1, 1'b0, 1'b0);
		reg_write(6'h02, 8'h3f);
		lat_chk(3'h0, 3'h0, 1'b0);
		set_sel(1'b1, 1'b1, 1'b0);
		lat_chk(3'h7, 3'h7, 1'b0);
		set_sel(1'b0, 1'b0, 1'b0);
		reg_write(6'h03, 8'hff);
		lat_chk(3'h0, 3'h0, 1'b0);
		$display("test set points done");
		// only the clearing write is sent while leveling
		reg_write(6'h02, 8'h80);
		repeat (20) @(posedge clk);
		check(write_leveling_q, 17'h1, "leveling held");
		reg_write(6'h02, 8'h00);
		check(write_leveling_q, 17'h0, "leveling cleared");
		$display("test leveling done");
		for (int i = 0; i < 16; i++) burst(1'b0, i[3], {i[2:0], 2'($random(seed))});
		for (int i = 0; i < 4; i++) burst(1'b1, i[1], {i[0], 4'($random(seed))});
		$display("test bursts done");
		issue(blc_pkg::CMD_MRR, 1'b0, 5'h00, 6'h02, 8'h00);
		for (int k = 0; k < 40 && strobe_q !== 1'b1; k++) @(negedge clk);
		if (strobe_q !== 1'b1) begin
			err_count++;
			finish_test();
		end
		check(mrr_data_q, blc_pkg::MRR_FILL, "mode read data");
		s = strobe_q;
		@(negedge clk);
		check(strobe_q, {16'h0, ~s}, "mode read strobe");
		$display("test mode read done");
		finish_test();
	end
endmodule : test_burst_order_latency_config
